// ==== core/agt_pkg.sv ====
// Package of constants and types for the auxiliary pin and test source bank
package agt_pkg;
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 8;
   localparam int          PIN_N           = 8;
   // Register offsets
   localparam logic [3:0]  OFF_PIN_CONNECT = 4'h0;
   localparam logic [3:0]  OFF_PIN_DIR     = 4'h1;
   localparam logic [3:0]  OFF_PIN_DATA    = 4'h2;
   localparam logic [3:0]  OFF_TSRC_POS    = 4'h3;
   localparam logic [3:0]  OFF_TSRC_NEG    = 4'h4;
   localparam logic [3:0]  OFF_TSRC_CTRL   = 4'h5;
   localparam logic [3:0]  OFF_TSRC_STAT   = 4'h6;
   // Field positions
   localparam int          ROUTE_POS_BIT   = 0;
   localparam int          ROUTE_NEG_BIT   = 1;
   localparam int          STAT_POS_OK_BIT = 0;
   localparam int          STAT_NEG_OK_BIT = 1;
   localparam int          STAT_SE_BIT     = 2;
   localparam int          STAT_DIFF_BIT   = 3;
   localparam int          STAT_CM_BIT     = 4;
   // Reset values
   localparam logic [7:0]  RST_PIN_CONNECT = 8'h00;
   localparam logic [7:0]  RST_PIN_DIR     = 8'hff;
   localparam logic [7:0]  RST_PIN_DATA    = 8'h00;
   localparam logic [7:0]  RST_TSRC        = 8'h00;
   localparam logic [7:0]  RST_TSRC_CTRL   = 8'h00;
   // Test source codes
   localparam logic [7:0]  TSRC_MID        = 8'h00;
   localparam logic [7:0]  TSRC_UP_MAX     = 8'h09;
   localparam logic [7:0]  TSRC_DN_MIN     = 8'h11;
   localparam logic [7:0]  TSRC_DN_MAX     = 8'h19;
   localparam logic [7:0]  TSRC_DN_FLAG    = 8'h10;
   // Ratio in units of 1/640 of the supply span
   localparam logic [9:0]  RATIO_MID       = 10'h140;

   typedef enum logic [1:0] {
      AGT_DIR_MID,
      AGT_DIR_UP,
      AGT_DIR_DOWN,
      AGT_DIR_BAD
   } agt_dir_t;

   // Decodes a code into its direction: mid, up, down or bad
   function automatic agt_dir_t agt_code_dir(input logic [7:0] code);
      if (code == TSRC_MID)
         return AGT_DIR_MID;
      else if (code <= TSRC_UP_MAX)
         return AGT_DIR_UP;
      else if (code >= TSRC_DN_MIN && code <= TSRC_DN_MAX)
         return AGT_DIR_DOWN;
      else
         return AGT_DIR_BAD;
   endfunction
endpackage : agt_pkg

// ==== core/agt_tsrc_if.sv ====
// Interface carrying one test source channel between modules
`timescale 1ns/10ps
interface agt_tsrc_if;
   logic [7:0] code;
   logic       valid;
   logic [9:0] ratio;
   logic       route;
   modport ctrl (output code, output route, input valid, input ratio);
   modport dac  (input code, input route, output valid, output ratio);
endinterface : agt_tsrc_if

// ==== core/agt_tsrc_dec.sv ====
// Test source code decoder: code to divider ratio
`timescale 1ns/10ps
module agt_tsrc_dec
   import agt_pkg::*;
(
   agt_tsrc_if.dac  ch
);
   // ===============================================================
   // Ratio table, 1/640 of span: steps 1,2,4,...,64 then 128 and 256
   logic [9:0] step;
   logic [3:0] idx;
   agt_dir_t   dir;

   assign dir = agt_code_dir(ch.code);
   assign idx = ch.code[3:0];

   always_comb begin
      step = 10'h000;
      unique case (idx)
         4'h1:    step = 10'h001;
         4'h2:    step = 10'h002;
         4'h3:    step = 10'h004;
         4'h4:    step = 10'h008;
         4'h5:    step = 10'h010;
         4'h6:    step = 10'h020;
         4'h7:    step = 10'h040;
         4'h8:    step = 10'h080;
         4'h9:    step = 10'h100;
         default: step = 10'h000;
      endcase
   end

   assign ch.valid = (dir != AGT_DIR_BAD);
   assign ch.ratio = (dir == AGT_DIR_UP)   ? RATIO_MID + step :
                     (dir == AGT_DIR_DOWN) ? RATIO_MID - step :
                     RATIO_MID;
endmodule // agt_tsrc_dec

// ==== core/agt_pin_cell.sv ====
// One general-purpose pin cell
`timescale 1ns/10ps
module agt_pin_cell (
   input  wire logic connect,
   input  wire logic dir_in,
   input  wire logic data_wr,
   input  wire logic pin_in,
   output wire logic pin_out,
   output wire logic pin_oe_n,
   output wire logic data_rd
);
   // ===============================================================
   // Drive only when attached and set as output
   assign pin_oe_n = ~(connect & ~dir_in);
   assign pin_out  = data_wr & connect & ~dir_in;
   assign data_rd  = connect & dir_in & pin_in;
endmodule // agt_pin_cell

// ==== core/aux_gpio_test_dac_ctrl.sv ====
// Auxiliary pin function and test voltage source register bank
// ===============================================================
// Overview of operation
// - Eight analog inputs usable as digital pins
// - Connect bit one attaches pin function
// - Direction bit zero output, one input
// - Data register drives outputs, reads inputs
// - Output pins read back as zero
// - Positive and negative channels, own code
// - Route bits put channels on pins
// - Code zero gives mid-supply ratio
// - Steps up 01-09, down 11-19 only
`timescale 1ns/10ps
module aux_gpio_test_dac_ctrl
   import agt_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire logic [agt_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [agt_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic      [agt_pkg::DATA_W-1:0] reg_rdata,
   input  wire logic [agt_pkg::PIN_N-1:0]  pin_in,
   output logic      [agt_pkg::PIN_N-1:0]  pin_out,
   output logic      [agt_pkg::PIN_N-1:0]  pin_oe_n,
   output logic      [9:0]                 tsrc_pos_ratio,
   output logic      [9:0]                 tsrc_neg_ratio,
   output logic                            tsrc_pos_to_pin,
   output logic                            tsrc_neg_to_pin
);
   import agt_pkg::*;

   // ===============================================================
   // Registers
   logic [7:0] pin_connect_reg;
   logic [7:0] pin_direction_reg;
   logic [7:0] pin_data_reg;
   logic [7:0] tsrc_pos_reg;
   logic [7:0] tsrc_neg_reg;
   logic [7:0] tsrc_ctrl_reg;
   logic [7:0] rdata_next;

   // ===============================================================
   // Decode
   wire        wr_connect = reg_wr && reg_addr == OFF_PIN_CONNECT;
   wire        wr_dir     = reg_wr && reg_addr == OFF_PIN_DIR;
   wire        wr_data    = reg_wr && reg_addr == OFF_PIN_DATA;
   wire        wr_pos     = reg_wr && reg_addr == OFF_TSRC_POS;
   wire        wr_neg     = reg_wr && reg_addr == OFF_TSRC_NEG;
   wire        wr_ctrl    = reg_wr && reg_addr == OFF_TSRC_CTRL;

   // ===============================================================
   // Pin cells
   wire  [7:0] cell_out;
   wire  [7:0] cell_oe_n;
   wire  [7:0] cell_rd;

   for (genvar i = 0; i < PIN_N; i++) begin : g_pin
      agt_pin_cell u_cell (
         .connect  (pin_connect_reg[i]),
         .dir_in   (pin_direction_reg[i]),
         .data_wr  (pin_data_reg[i]),
         .pin_in   (pin_in[i]),
         .pin_out  (cell_out[i]),
         .pin_oe_n (cell_oe_n[i]),
         .data_rd  (cell_rd[i])
      );
   end

   // ===============================================================
   // Test source channels
   agt_tsrc_if pos_ch ();
   agt_tsrc_if neg_ch ();

   assign pos_ch.code  = tsrc_pos_reg;
   assign neg_ch.code  = tsrc_neg_reg;
   assign pos_ch.route = tsrc_ctrl_reg[ROUTE_POS_BIT];
   assign neg_ch.route = tsrc_ctrl_reg[ROUTE_NEG_BIT];

   agt_tsrc_dec u_pos_dec (.ch (pos_ch.dac));
   agt_tsrc_dec u_neg_dec (.ch (neg_ch.dac));

   // Status hints for software test setups; chopping is outside this bank
   wire        is_se   = tsrc_neg_reg == TSRC_MID;
   wire        is_cm   = tsrc_pos_reg == tsrc_neg_reg;
   wire        is_diff = pos_ch.valid && neg_ch.valid && !is_cm
                         && tsrc_pos_reg[3:0] == tsrc_neg_reg[3:0];
   wire  [7:0] stat_val = {3'h0, is_cm, is_diff, is_se, neg_ch.valid, pos_ch.valid};

   // ===============================================================
   // Read mux; unmapped offsets read zero
   always_comb begin
      rdata_next = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            OFF_PIN_CONNECT: rdata_next = pin_connect_reg;
            OFF_PIN_DIR:     rdata_next = pin_direction_reg;
            OFF_PIN_DATA:    rdata_next = cell_rd;
            OFF_TSRC_POS:    rdata_next = tsrc_pos_reg;
            OFF_TSRC_NEG:    rdata_next = tsrc_neg_reg;
            OFF_TSRC_CTRL:   rdata_next = tsrc_ctrl_reg;
            OFF_TSRC_STAT:   rdata_next = stat_val;
            default:         rdata_next = 8'h00;
         endcase
      end
   end

   // ===============================================================
   // Register writes
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_connect_reg   <= RST_PIN_CONNECT;
         pin_direction_reg <= RST_PIN_DIR;
         pin_data_reg      <= RST_PIN_DATA;
         tsrc_pos_reg      <= RST_TSRC;
         tsrc_neg_reg      <= RST_TSRC;
         tsrc_ctrl_reg     <= RST_TSRC_CTRL;
      end else begin
         if (wr_connect) pin_connect_reg <= reg_wdata;
         if (wr_dir) pin_direction_reg <= reg_wdata;
         // Value is stored even for inputs, so it applies on turnaround
         if (wr_data) pin_data_reg <= reg_wdata;
         if (wr_pos) tsrc_pos_reg <= reg_wdata;
         if (wr_neg) tsrc_neg_reg <= reg_wdata;
         if (wr_ctrl) tsrc_ctrl_reg <= {6'h00, reg_wdata[1:0]};
      end
   end

   // ===============================================================
   // Registered outputs
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata       <= 8'h00;
         pin_out         <= 8'h00;
         pin_oe_n        <= 8'hff;
         tsrc_pos_ratio  <= RATIO_MID;
         tsrc_neg_ratio  <= RATIO_MID;
         tsrc_pos_to_pin <= 1'b0;
         tsrc_neg_to_pin <= 1'b0;
      end else begin
         reg_rdata       <= rdata_next;
         pin_out         <= cell_out;
         pin_oe_n        <= cell_oe_n;
         tsrc_pos_ratio  <= pos_ch.ratio;
         tsrc_neg_ratio  <= neg_ch.ratio;
         tsrc_pos_to_pin <= pos_ch.route;
         tsrc_neg_to_pin <= neg_ch.route;
      end
   end
endmodule // aux_gpio_test_dac_ctrl

// ==== tb/agt_ctrl_asserts.sv ====
// Checker for register bank timing and output relations
`timescale 1ns/10ps
module agt_ctrl_asserts
   import agt_pkg::*;
(
   input wire logic                       clk,
   input wire logic                       sys_rst,
   input wire logic [agt_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [agt_pkg::DATA_W-1:0] reg_wdata,
   input wire logic                       reg_wr,
   input wire logic                       reg_rd,
   input wire logic [agt_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [agt_pkg::PIN_N-1:0]  pin_in,
   input wire logic [agt_pkg::PIN_N-1:0]  pin_out,
   input wire logic [agt_pkg::PIN_N-1:0]  pin_oe_n,
   input wire logic [9:0]                 tsrc_pos_ratio,
   input wire logic [9:0]                 tsrc_neg_ratio,
   input wire logic                       tsrc_pos_to_pin,
   input wire logic                       tsrc_neg_to_pin
);
   // =====================================================
   // Decodes
   wire logic rd_dat = reg_rd && reg_addr == OFF_PIN_DATA;
   wire logic wr_ctl = reg_wr && reg_addr == OFF_TSRC_CTRL;
   wire logic wr_pos = reg_wr && reg_addr == OFF_TSRC_POS;
   wire logic wr_pin = reg_wr && reg_addr <= OFF_PIN_DIR;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // =====================================================
   // Properties
   rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
   rd_in_sense_a: assert property ($past(rd_dat) |-> (reg_rdata & ~$past(pin_in)) == '0)
      else $error("data read shows unsensed bit");
   rd_out_zero_a: assert property ($past(rd_dat) |-> (reg_rdata & ~pin_oe_n) == 8'h00)
      else $error("output pin read back nonzero");
   oe_drive_a: assert property ((pin_out & pin_oe_n) == 8'h00)
      else $error("pin level driven while not enabled");
   pos_route_a: assert property ($rose(tsrc_pos_to_pin) |-> $past(wr_ctl, 2))
      else $error("positive route without write");
   neg_route_a: assert property ($changed(tsrc_neg_to_pin) |-> $past(wr_ctl, 2))
      else $error("negative route without write");
   pos_ratio_a: assert property ($changed(tsrc_pos_ratio) |-> $past(wr_pos, 2))
      else $error("positive ratio moved without write");
   pin_change_a: assert property ($changed(pin_oe_n) |-> $past(wr_pin, 2))
      else $error("pin enable moved without write");
   dat_read_c: cover property (rd_dat);
   route_c: cover property ($rose(tsrc_neg_to_pin));
   ratio_c: cover property ($changed(tsrc_neg_ratio));
endmodule // agt_ctrl_asserts

bind aux_gpio_test_dac_ctrl agt_ctrl_asserts agt_ctrl_asserts_inst (.clk(clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
   .tsrc_pos_ratio(tsrc_pos_ratio), .tsrc_neg_ratio(tsrc_neg_ratio),
   .tsrc_pos_to_pin(tsrc_pos_to_pin), .tsrc_neg_to_pin(tsrc_neg_to_pin));

// ==== tb/test_aux_gpio_test_dac_ctrl.sv ====
// Testbench for the auxiliary pin and test source register bank
`timescale 1ns/10ps
module test_aux_gpio_test_dac_ctrl;
   import agt_pkg::*;
   logic       clk, sys_rst, reg_wr, reg_rd, pos_pin, neg_pin;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe_n;
   logic [9:0] pos_r, neg_r;
   int         n_errors = 0;
   int         tests_run = 0;
   aux_gpio_test_dac_ctrl aux_gpio_test_dac_ctrl_inst (.clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .tsrc_pos_ratio(pos_r), .tsrc_neg_ratio(neg_r), .tsrc_pos_to_pin(pos_pin),
      .tsrc_neg_to_pin(neg_pin));
   // =====================================================
   // Bus and compare tasks
   task chk(input logic [9:0] got, input logic [9:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   // Outputs follow a write by two edges
   task settle;
      repeat (2) @(posedge clk);
      #1;
   endtask
   // =====================================================
   // Scenarios
   task t_reset;
      logic [7:0] rv [8];
      rv = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h17, 8'h00};
      for (int a = 0; a < 8; a++) rd(a[3:0], rv[a]);
      chk(pin_oe_n, 8'hff);
      chk(pos_r, 10'h140);
      wr(4'h7, 8'h5a);
      wr(4'h6, 8'h00);
      rd(4'h7, 8'h00);
      rd(4'h6, 8'h17);
   endtask
   task t_gpio;
      pin_in <= 8'h3c;
      wr(OFF_PIN_CONNECT, 8'hff); wr(OFF_PIN_DIR, 8'h0f); wr(OFF_PIN_DATA, 8'ha5); settle;
      chk(pin_oe_n, 8'h0f);
      chk(pin_out, 8'ha0);
      rd(OFF_PIN_DATA, 8'h0c);
      wr(OFF_PIN_DIR, 8'hff); wr(OFF_PIN_DATA, 8'h5a); settle;
      chk(pin_out, 8'h00);
      rd(OFF_PIN_DATA, 8'h3c);
      wr(OFF_PIN_DIR, 8'h00); settle;
      chk(pin_out, 8'h5a);
      rd(OFF_PIN_DATA, 8'h00);
      wr(OFF_PIN_CONNECT, 8'h00); settle;
      chk(pin_oe_n, 8'hff);
   endtask
   task t_codes;
      logic [9:0] st;
      for (int k = 0; k < 10; k++) begin
         st = (k == 0) ? 10'h0 : 10'h1 << (k - 1);
         wr(OFF_TSRC_POS, k[7:0]); wr(OFF_TSRC_NEG, (k == 0) ? 8'h00 : 8'h10 | k[7:0]); settle;
         chk(pos_r, 10'h140 + st);
         chk(neg_r, 10'h140 - st);
         rd(OFF_TSRC_STAT, (k == 0) ? 8'h17 : 8'h0b);
      end
      wr(OFF_TSRC_POS, 8'h05); wr(OFF_TSRC_NEG, 8'h05); wr(OFF_TSRC_NEG, 8'h0a); settle;
      chk(neg_r, 10'h140);
      wr(OFF_TSRC_NEG, 8'h05);
      rd(OFF_TSRC_STAT, 8'h13);
      // Chopping lives outside this bank, so the bench never turns it on
      wr(OFF_TSRC_NEG, TSRC_MID); wr(OFF_TSRC_POS, 8'h03); settle;
      chk(pos_r, 10'h144);
      chk(neg_r, 10'h140);
      rd(OFF_TSRC_STAT, 8'h07);
      wr(OFF_TSRC_POS, 8'h13); settle;
      chk(pos_r, 10'h13c);
   endtask
   task t_route;
      wr(OFF_TSRC_CTRL, 8'h03); settle;
      chk({pos_pin, neg_pin}, 10'h3);
      rd(OFF_TSRC_CTRL, 8'h03);
      wr(OFF_TSRC_CTRL, 8'hfe); settle;
      chk({pos_pin, neg_pin}, 10'h1);
      rd(OFF_TSRC_CTRL, 8'h02);
      // A second reset mid-run must clear the routing, then writes work again
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      #1 chk({pos_pin, neg_pin}, 10'h0);
      rd(OFF_PIN_DIR, 8'hff);
      wr(OFF_TSRC_CTRL, 8'h01); settle;
      chk({pos_pin, neg_pin}, 10'h2);
   endtask
   task end_sim;
      $display("errors %0d, checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // =====================================================
   // Clock, reset, sequence and watchdog
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
      reg_addr = 4'h0; reg_wdata = 8'h00; pin_in = 8'h00;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset; t_gpio; t_codes; t_route;
      end_sim;
   end
   initial begin
      #20000;
      n_errors++;
      end_sim;
   end
endmodule // test_aux_gpio_test_dac_ctrl
